// ---- sfg_params.svh ----
// Constants for the serial flash write guard and pause logic
`ifndef SFG_PARAMS_SVH
`define SFG_PARAMS_SVH

// Command opcodes
`define SFG_OP_SET      8'h06
`define SFG_OP_CLR      8'h04
`define SFG_OP_PROG     8'h02
`define SFG_OP_QPROG    8'h32
`define SFG_OP_OTPROG   8'h42
`define SFG_OP_ERASE    8'hD8
`define SFG_OP_BULK     8'hC7
`define SFG_OP_PERASE4  8'h20
`define SFG_OP_PERASE8  8'h40
`define SFG_OP_REGW     8'h01
`define SFG_OP_NONE     8'h00

// Frame bytes needed before a command may run
`define SFG_NEED_BARE   3'h1
`define SFG_NEED_ADDR   3'h4
`define SFG_NEED_DATA   3'h5
`define SFG_BYTE_MAX    3'h5

// Address layout: 64 kB sector index bits
`define SFG_SEC_HI      22
`define SFG_SEC_LO      16
`define SFG_SEC_TOP     8'h80

// Status data byte layout for register write
`define SFG_STATUS_WRITE_DISABLE_BIT_BIT    7
`define SFG_BP_HI       4
`define SFG_BP_LO       2

// Reset values and protection code limits
`define SFG_BP_RST      3'h0
`define SFG_STATUS_WRITE_DISABLE_BIT_RST    1'h0
`define SFG_BP_NONE     3'h0
`define SFG_BP_ALL      3'h7
`define SFG_BIT_ZERO    3'h0

`endif

// ---- sfg_pkg.sv ----
// Types shared by the serial flash write guard
package sfg_pkg;
	typedef enum logic [2:0] {CK_NONE, CK_SET, CK_CLR, CK_PROG, CK_ERASE,
		CK_BULK, CK_REGW} sfg_kind_t;
	typedef enum logic [1:0] {HS_RUN, HS_ENTER, HS_HOLD, HS_EXIT} sfg_hold_t;
endpackage : sfg_pkg

// ---- sfg_guard.sv ----
// Serial flash write-enable latch, block protection and pause logic
// Functional notes
// - Latch clears at reset, on write completion, register write, clear command.
// - Protected addresses stay readable; program or erase there is refused.
// - Origin top: code n protects highest 2^n sectors; 0 none, 7 all.
// - Origin bottom: code n protects lowest 2^n sectors; 0 none, 7 all.
// - Hardware protection comes from protect pin plus status write-disable bit.
// - Write-disable set with protect pin low makes status bits read-only.
// - Modifying commands run only if clock count is a multiple of eight.
// - Pause stops serial traffic only; internal write runs on unaffected.
// - Pause starts at pause fall if clock low, else next clock fall.
// - Pause ends at pause rise if clock low, else next clock fall.
// - While paused, output floats and data and clock inputs are ignored.
// - Chip select high while paused resets the serial interface.
// - Four-bit I/O mode disables the pause function entirely.
// - Origin bit 1 anchors protection low, 0 anchors it high.
`timescale 1ns/10ps
`include "sfg_params.svh"

module sfg_guard
	import sfg_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        CS_N,
	input  wire logic        SCK,
	input  wire logic        SI,
	input  wire logic        HOLD_N,
	input  wire logic        WP_N,
	input  wire logic        QUAD_EN,
	input  wire logic        PROT_ORIGIN,
	input  wire logic        SO_DATA,
	input  wire logic        SO_EN,
	input  wire logic        BUSY,
	input  wire logic        OP_DONE,
	output logic             SO,
	output logic             SO_OE,
	output logic             WRITE_ENABLE_LATCH_BIT,
	output logic [2:0]       BP,
	output logic             STATUS_WRITE_DISABLE_BIT,
	output logic             HW_PROT,
	output logic             HOLD_ACTIVE,
	output logic             OP_START,
	output sfg_kind_t        OP_KIND,
	output logic [23:0]      OP_ADDR,
	output logic             CMD_REFUSED
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Map an opcode onto its command class
	function automatic sfg_kind_t kind_of(input logic [7:0] op);
		case (op)
			`SFG_OP_SET:     kind_of = CK_SET;
			`SFG_OP_CLR:     kind_of = CK_CLR;
			`SFG_OP_PROG,
			`SFG_OP_QPROG,
			`SFG_OP_OTPROG:  kind_of = CK_PROG;
			`SFG_OP_ERASE,
			`SFG_OP_PERASE4,
			`SFG_OP_PERASE8: kind_of = CK_ERASE;
			`SFG_OP_BULK:    kind_of = CK_BULK;
			`SFG_OP_REGW:    kind_of = CK_REGW;
			default:         kind_of = CK_NONE;
		endcase
	endfunction : kind_of

	// True when the address falls in the block-protected region
	function automatic logic prot_hit(input logic [23:0] a,
		input logic [2:0] bp, input logic low_end);
		logic [7:0] sec;
		logic [7:0] span;
		sec  = {1'b0, a[`SFG_SEC_HI:`SFG_SEC_LO]};
		span = 8'h01 << bp;
		if (bp == `SFG_BP_NONE)
			prot_hit = 1'b0;
		else if (bp == `SFG_BP_ALL)
			prot_hit = 1'b1;
		else if (low_end)
			prot_hit = sec < span;
		else
			prot_hit = sec >= (`SFG_SEC_TOP - span);
	endfunction : prot_hit

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [2:0] cs_s, sck_s, hold_s;
	logic [1:0] si_s, wp_s;

	// Two flops per pin, third flop only for edge finding
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cs_s   <= 3'h7;
			sck_s  <= 3'h0;
			hold_s <= 3'h7;
			si_s   <= 2'h0;
			wp_s   <= 2'h3;
		end else begin
			cs_s   <= {cs_s[1:0], CS_N};
			sck_s  <= {sck_s[1:0], SCK};
			hold_s <= {hold_s[1:0], HOLD_N};
			si_s   <= {si_s[0], SI};
			wp_s   <= {wp_s[0], WP_N};
		end
	end

	logic cs_hi, cs_rise, sck_lo, sck_rise, sck_fall, hold_fall, hold_rise;
	assign cs_hi     = cs_s[1];
	assign cs_rise   = cs_s[1] & ~cs_s[2];
	assign sck_lo    = ~sck_s[1];
	assign sck_rise  = sck_s[1] & ~sck_s[2];
	assign sck_fall  = ~sck_s[1] & sck_s[2];
	assign hold_fall = ~hold_s[1] & hold_s[2];
	assign hold_rise = hold_s[1] & ~hold_s[2];

	////////////////////////////////////////////////////////////////////////
	// Pause state machine

	sfg_hold_t hold_st, next_hold_st;
	logic      paused;
	assign paused = (hold_st == HS_HOLD) || (hold_st == HS_EXIT);

	// Pause entry and exit timing
	always_comb begin
		next_hold_st = hold_st;
		if (QUAD_EN || cs_hi) begin
			next_hold_st = HS_RUN;
		end else begin
			case (hold_st)
				HS_RUN: begin
					if (hold_fall)
						next_hold_st = sck_lo ? HS_HOLD : HS_ENTER;
				end
				HS_ENTER: begin
					if (sck_fall)
						next_hold_st = HS_HOLD;
				end
				HS_HOLD: begin
					if (hold_rise)
						next_hold_st = sck_lo ? HS_RUN : HS_EXIT;
				end
				HS_EXIT: begin
					if (sck_fall)
						next_hold_st = HS_RUN;
				end
				default: next_hold_st = HS_RUN;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			hold_st <= HS_RUN;
		else
			hold_st <= next_hold_st;
	end

	////////////////////////////////////////////////////////////////////////
	// Serial capture and command execution

	logic [2:0]  bit_cnt, next_bit_cnt, byte_cnt, next_byte_cnt;
	logic [7:0]  shreg, next_shreg, opcode, next_opcode, dbyte, next_dbyte;
	logic [23:0] addr, next_addr, next_op_addr;
	logic        next_wel, next_status_write_disable_bit, next_hw_prot, next_op_start;
	logic        next_refused, next_so, next_so_oe;
	logic [2:0]  next_bp;
	sfg_kind_t   kind, next_op_kind;
	logic        hit, ok, need_ok;
	logic [7:0]  byte_in;

	assign kind    = kind_of(opcode);
	assign hit     = prot_hit(addr, BP, PROT_ORIGIN);
	assign byte_in = {shreg[6:0], si_s[1]};

	always_comb begin
		next_bit_cnt  = bit_cnt;
		next_byte_cnt = byte_cnt;
		next_shreg    = shreg;
		next_opcode   = opcode;
		next_addr     = addr;
		next_dbyte    = dbyte;
		next_wel      = WRITE_ENABLE_LATCH_BIT;
		next_bp       = BP;
		next_status_write_disable_bit     = STATUS_WRITE_DISABLE_BIT;
		next_op_start = 1'b0;
		next_op_kind  = OP_KIND;
		next_op_addr  = OP_ADDR;
		next_refused  = 1'b0;
		need_ok       = 1'b0;
		ok            = 1'b0;
		next_hw_prot  = STATUS_WRITE_DISABLE_BIT & ~wp_s[1];
		next_so       = SO_DATA;
		next_so_oe    = ~cs_hi & ~paused & SO_EN;
		// Completion of an internal write clears the latch
		if (OP_DONE)
			next_wel = 1'b0;
		if (cs_rise) begin
			// Frame end: reset interface, run a complete command
			next_bit_cnt  = `SFG_BIT_ZERO;
			next_byte_cnt = `SFG_BIT_ZERO;
			next_opcode   = `SFG_OP_NONE;  // Empty next frame runs nothing stale
			case (kind)
				CK_SET, CK_CLR, CK_BULK: need_ok = byte_cnt == `SFG_NEED_BARE;
				CK_ERASE: need_ok = byte_cnt == `SFG_NEED_ADDR;
				CK_PROG:  need_ok = byte_cnt >= `SFG_NEED_DATA;
				CK_REGW:  need_ok = byte_cnt >= `SFG_NEED_ADDR - 3'h2;
				default:  need_ok = 1'b0;
			endcase
			ok = need_ok && bit_cnt == `SFG_BIT_ZERO && !paused;
			case (kind)
				CK_SET: if (ok && !BUSY) next_wel = 1'b1;
				CK_CLR: if (ok && !BUSY) next_wel = 1'b0;
				CK_REGW: begin
					if (ok && WRITE_ENABLE_LATCH_BIT && !BUSY && !HW_PROT) begin
						next_status_write_disable_bit = dbyte[`SFG_STATUS_WRITE_DISABLE_BIT_BIT];
						next_bp   = dbyte[`SFG_BP_HI:`SFG_BP_LO];
						next_wel  = 1'b0;
					end else begin
						next_refused = 1'b1;
					end
				end
				CK_PROG, CK_ERASE, CK_BULK: begin
					if (ok && WRITE_ENABLE_LATCH_BIT && !BUSY && !HW_PROT &&
						!(kind == CK_BULK ? BP != `SFG_BP_NONE : hit)) begin
						next_op_start = 1'b1;
						next_op_kind  = kind;
						next_op_addr  = addr;
					end else begin
						next_refused = 1'b1;
					end
				end
				default: next_refused = 1'b0;
			endcase
		end else if (cs_hi) begin
			next_bit_cnt  = `SFG_BIT_ZERO;
			next_byte_cnt = `SFG_BIT_ZERO;
		end else if (sck_rise && !paused) begin
			// Serial inputs are taken only outside pause
			next_shreg   = byte_in;
			next_bit_cnt = bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				case (byte_cnt)
					3'h0:    next_opcode = byte_in;
					3'h1:    next_addr[23:16] = byte_in;
					3'h2:    next_addr[15:8] = byte_in;
					3'h3:    next_addr[7:0] = byte_in;
					default: next_addr = addr;
				endcase
				if (byte_cnt == 3'h1)
					next_dbyte = byte_in;
				if (byte_cnt != `SFG_BYTE_MAX)
					next_byte_cnt = byte_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			bit_cnt     <= `SFG_BIT_ZERO;
			byte_cnt    <= `SFG_BIT_ZERO;
			shreg       <= 8'h00;
			opcode      <= 8'h00;
			addr        <= 24'h000000;
			dbyte       <= 8'h00;
			WRITE_ENABLE_LATCH_BIT         <= 1'b0;
			BP          <= `SFG_BP_RST;
			STATUS_WRITE_DISABLE_BIT        <= `SFG_STATUS_WRITE_DISABLE_BIT_RST;
			HW_PROT     <= 1'b0;
			HOLD_ACTIVE <= 1'b0;
			OP_START    <= 1'b0;
			OP_KIND     <= CK_NONE;
			OP_ADDR     <= 24'h000000;
			CMD_REFUSED <= 1'b0;
			SO          <= 1'b0;
			SO_OE       <= 1'b0;
		end else begin
			bit_cnt     <= next_bit_cnt;
			byte_cnt    <= next_byte_cnt;
			shreg       <= next_shreg;
			opcode      <= next_opcode;
			addr        <= next_addr;
			dbyte       <= next_dbyte;
			WRITE_ENABLE_LATCH_BIT         <= next_wel;
			BP          <= next_bp;
			STATUS_WRITE_DISABLE_BIT        <= next_status_write_disable_bit;
			HW_PROT     <= next_hw_prot;
			HOLD_ACTIVE <= (next_hold_st == HS_HOLD) || (next_hold_st == HS_EXIT);
			OP_START    <= next_op_start;
			OP_KIND     <= next_op_kind;
			OP_ADDR     <= next_op_addr;
			CMD_REFUSED <= next_refused;
			SO          <= next_so;
			SO_OE       <= next_so_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	property p_start_needs_wel;
		OP_START |-> $past(WRITE_ENABLE_LATCH_BIT);
	endproperty
	a_start_needs_wel: assert property (p_start_needs_wel)
		else $error("write started without latch");

	property p_count_whole;
		OP_START |-> $past(bit_cnt) == 3'h0 && $past(cs_rise);
	endproperty
	a_count_whole: assert property (p_count_whole)
		else $error("write started on partial byte");

	property p_prot_refused;
		cs_rise && hit && kind != CK_BULK |=> !OP_START;
	endproperty
	a_prot_refused: assert property (p_prot_refused)
		else $error("protected address written");

	property p_status_locked;
		HW_PROT |=> $stable(BP) && $stable(STATUS_WRITE_DISABLE_BIT);
	endproperty
	a_status_locked: assert property (p_status_locked)
		else $error("status changed under hardware protection");

	property p_float_paused;
		paused |=> !SO_OE;
	endproperty
	a_float_paused: assert property (p_float_paused)
		else $error("output driven while paused");

	property p_enter_pause;
		hold_st == HS_RUN && hold_fall && sck_lo && !cs_hi && !QUAD_EN
			|=> HOLD_ACTIVE;
	endproperty
	a_enter_pause: assert property (p_enter_pause)
		else $error("pause not entered");

	property p_leave_pause;
		hold_st == HS_HOLD && hold_rise && sck_lo |=> !HOLD_ACTIVE;
	endproperty
	a_leave_pause: assert property (p_leave_pause)
		else $error("pause not left");

	property p_cs_reset;
		paused && cs_rise |=> !paused && bit_cnt == 3'h0 && !OP_START;
	endproperty
	a_cs_reset: assert property (p_cs_reset)
		else $error("interface not reset");

	property p_quad_nopause;
		QUAD_EN |=> !HOLD_ACTIVE;
	endproperty
	a_quad_nopause: assert property (p_quad_nopause)
		else $error("pause active in quad mode");

	property p_refuse_nostart;
		CMD_REFUSED |-> !OP_START;
	endproperty
	a_refuse_nostart: assert property (p_refuse_nostart)
		else $error("refused command started");

	c_start: cover property (OP_START);
	c_refused: cover property (CMD_REFUSED && $past(WRITE_ENABLE_LATCH_BIT));
	c_pause_late: cover property (hold_st == HS_ENTER ##[1:50] HOLD_ACTIVE);
	c_exit_late: cover property (hold_st == HS_EXIT ##[1:50] !HOLD_ACTIVE);

endmodule : sfg_guard

// ---- sfg_host.sv ----
// Serial bus host model that drives frames into the write guard
`timescale 1ns/10ps

module sfg_host (
	input  wire logic MCLK,
	output logic      CS_N,
	output logic      SCK,
	output logic      SI,
	output logic      HOLD_N
);
	// Idle pins at time zero
	initial begin
		CS_N = 1'b1;
		SCK = 1'b0;
		SI = 1'b0;
		HOLD_N = 1'b1;
	end

	// Waits a number of system clock edges
	task wc(input int n);
		repeat (n) @(posedge MCLK);
	endtask : wc

	// One frame MSB first; mode 1 pauses mid-frame, mode 2 deselects paused
	task send(input logic [39:0] d, input int n, input int mode);
		@(posedge MCLK);
		CS_N <= 1'b0;
		wc(10);
		for (int i = 0; i < n; i++) begin
			SI <= d[39 - i];
			wc(10);
			if (i == 12 && mode != 0) begin
				HOLD_N <= 1'b0;
				wc(12);
				repeat (2) begin
					SCK <= 1'b1;
					SI <= ~SI;
					wc(4);
					SCK <= 1'b0;
					wc(4);
				end
				if (mode == 2) begin
					CS_N <= 1'b1;
					wc(8);
					HOLD_N <= 1'b1;
					wc(20);
					return;
				end
				HOLD_N <= 1'b1;
				wc(8);
				SI <= d[39 - i];
				wc(4);
			end
			SCK <= 1'b1;
			wc(10);
			SCK <= 1'b0;
		end
		wc(10);
		CS_N <= 1'b1;
		SI <= ~SI; // Released line does not keep its last value
		wc(20);
	endtask : send
endmodule : sfg_host

// ---- sfg_guard_tb.sv ----
// Self-checking bench for the serial flash write guard
`timescale 1ns/10ps

module sfg_guard_tb;
	import sfg_pkg::*;
	typedef struct packed {logic st; sfg_kind_t k; logic [23:0] a;} sfg_exp_t;
	logic MCLK, RST_N, CS_N, SCK, SI, HOLD_N, WP_N, QUAD_EN, PROT_ORIGIN;
	logic SO_DATA, SO_EN, BUSY, OP_DONE, SO, SO_OE, WRITE_ENABLE_LATCH_BIT, STATUS_WRITE_DISABLE_BIT, HW_PROT;
	logic HOLD_ACTIVE, OP_START, CMD_REFUSED;
	logic [2:0]  BP;
	logic [23:0] OP_ADDR, a, sz, pa;
	sfg_kind_t   OP_KIND;
	sfg_exp_t    expq[$], e;
	int          err_count, comparisons, seed, bcnt, hcnt, ccnt;
	logic        so_d, en_d, rdy;
	logic [7:0]  ops[7] = '{8'h02, 8'h32, 8'h42, 8'hD8, 8'h20, 8'h40, 8'hC7};
	sfg_kind_t   kinds[7] = '{CK_PROG, CK_PROG, CK_PROG, CK_ERASE, CK_ERASE,
		CK_ERASE, CK_BULK};

	sfg_host sfg_host_i (.MCLK(MCLK), .CS_N(CS_N), .SCK(SCK), .SI(SI),
		.HOLD_N(HOLD_N));
	sfg_guard sfg_guard_i (.MCLK(MCLK), .RST_N(RST_N), .CS_N(CS_N),
		.SCK(SCK), .SI(SI), .HOLD_N(HOLD_N), .WP_N(WP_N),
		.QUAD_EN(QUAD_EN), .PROT_ORIGIN(PROT_ORIGIN), .SO_DATA(SO_DATA),
		.SO_EN(SO_EN), .BUSY(BUSY), .OP_DONE(OP_DONE), .SO(SO),
		.SO_OE(SO_OE), .WRITE_ENABLE_LATCH_BIT(WRITE_ENABLE_LATCH_BIT), .BP(BP), .STATUS_WRITE_DISABLE_BIT(STATUS_WRITE_DISABLE_BIT), .HW_PROT(HW_PROT),
		.HOLD_ACTIVE(HOLD_ACTIVE), .OP_START(OP_START), .OP_KIND(OP_KIND),
		.OP_ADDR(OP_ADDR), .CMD_REFUSED(CMD_REFUSED));

	////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		MCLK = 1'b0;
		forever #2 MCLK = ~MCLK;
	end

	task check(input string what, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, x, s);
		end
	endtask : check

	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////
	// Random read path and internal write model
	always @(posedge MCLK) begin
		SO_DATA <= $random(seed);
		SO_EN <= $random(seed);
		OP_DONE <= 1'b0;
		if (OP_START === 1'b1) begin
			BUSY <= 1'b1;
			bcnt <= 30;
		end else if (bcnt == 1) begin
			BUSY <= 1'b0;
			OP_DONE <= 1'b1;
			bcnt <= 0;
		end else if (bcnt > 1)
			bcnt <= bcnt - 1;
	end

	// Result watcher pairs each pulse with the oldest note
	always @(posedge MCLK) begin
		hcnt <= (HOLD_N === 1'b0 && CS_N === 1'b0) ? hcnt + 1 : 0;
		ccnt <= (HOLD_N === 1'b1 && CS_N === 1'b0) ? ccnt + 1 : 0;
		// SO is a one-cycle registered copy of SO_DATA; SO_OE copies SO_EN only while selected and not paused
		so_d <= SO_DATA;
		en_d <= SO_EN;
		rdy  <= RST_N;
		if (rdy)
			check("so", 32'(SO), 32'(so_d));
		if (ccnt >= 8)
			check("so_oe drive", 32'(SO_OE), 32'(en_d));
		if (hcnt == 8 && QUAD_EN)
			check("pause off", 32'(HOLD_ACTIVE), 0);
		else if (hcnt == 8) begin
			check("pause", 32'(HOLD_ACTIVE), 1);
			check("so_oe", 32'(SO_OE), 0);
		end
		if (OP_START === 1'b1 || CMD_REFUSED === 1'b1) begin
			if (expq.size() == 0)
				check("unexpected", 1, 0);
			else begin
				e = expq.pop_front();
				check("start", 32'(OP_START), 32'(e.st));
				if (e.st && e.k != CK_BULK)
					check("addr", 32'(OP_ADDR), 32'(e.a));
				if (e.st)
					check("kind", 32'(OP_KIND), 32'(e.k));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sends one frame and waits out any internal write
	task go(input logic [39:0] d, input int n, input int m, input sfg_exp_t x);
		int i;
		expq.push_back(x);
		sfg_host_i.send(d, n, m);
		for (i = 0; i < 200 && (BUSY !== 1'b0 || bcnt != 0); i++)
			@(posedge MCLK);
		// Let the completion pulse reach the latch before looking
		repeat (2) @(posedge MCLK);
		if (i == 200) begin
			err_count++;
			stop_test();
		end
	endtask : go

	task setw;
		sfg_host_i.send({8'h06, 32'h0}, 8, 0);
		check("wel set", 32'(WRITE_ENABLE_LATCH_BIT), 1);
	endtask : setw

	task regw(input logic [7:0] v, input logic ok);
		setw();
		if (!ok)
			expq.push_back('0);
		sfg_host_i.send({8'h01, v, 24'h0}, 16, 0);
	endtask : regw

	// Main sequence
	initial begin
		{RST_N, QUAD_EN, PROT_ORIGIN, SO_DATA, SO_EN, BUSY, OP_DONE} = '0;
		{WP_N, bcnt, hcnt, ccnt, err_count, comparisons} = '0;
		WP_N = 1'b1;
		seed = 32'h2320;
		repeat (10) @(posedge MCLK);
		RST_N <= 1'b1;
		repeat (4) @(posedge MCLK);
		check("reset", 32'({WRITE_ENABLE_LATCH_BIT, BP, STATUS_WRITE_DISABLE_BIT}), 0);
		go({8'h02, 24'h001000, 8'hA5}, 40, 0, '0);
		for (int i = 0; i < 7; i++) begin
			setw();
			a = 24'($random(seed)) & 24'h7FFFFF;
			go({ops[i], a, 8'h5A}, i < 3 ? 40 : (i < 6 ? 32 : 8), 0,
				{1'b1, kinds[i], a});
			check("wel done", 32'(WRITE_ENABLE_LATCH_BIT), 0);
		end
		$display("test command kinds done");
		setw();
		sfg_host_i.send({8'h04, 32'h0}, 8, 0);
		check("wel clear", 32'(WRITE_ENABLE_LATCH_BIT), 0);
		setw();
		go({8'hD8, 32'h0}, 33, 0, '0);
		setw();
		go({8'h02, 24'h000100, 8'h11}, 40, 1, {1'b1, CK_PROG, 24'h000100});
		setw();
		go({8'h02, 24'h000200, 8'h22}, 40, 2, '0);
		QUAD_EN <= 1'b1;
		setw();
		go({8'h02, 24'h000300, 8'h33}, 40, 1, '0);
		QUAD_EN <= 1'b0;
		$display("test pause done");
		for (int o = 0; o < 2; o++)
			for (int n = 1; n < 7; n += 5) begin
				PROT_ORIGIN <= o[0];
				regw({3'h0, n[2:0], 2'h0}, 1'b1);
				check("bp", 32'({WRITE_ENABLE_LATCH_BIT, BP}), 32'(n));
				sz = 24'h010000 << n;
				pa = o ? sz - 24'h1 : 24'h800000 - sz;
				setw();
				go({8'hD8, pa, 8'h0}, 32, 0, '0);
				a = o ? sz : pa - 24'h1;
				setw();
				go({8'hD8, a, 8'h0}, 32, 0, {1'b1, CK_ERASE, a});
			end
		regw(8'h1C, 1'b1);
		setw();
		go({8'h20, 24'h000000, 8'h0}, 32, 0, '0);
		$display("test protection done");
		regw(8'h80, 1'b1);
		WP_N <= 1'b0;
		repeat (6) @(posedge MCLK);
		check("hw prot", 32'(HW_PROT), 1);
		regw(8'h1C, 1'b0);
		check("locked", 32'({STATUS_WRITE_DISABLE_BIT, BP}), 32'h8);
		WP_N <= 1'b1;
		repeat (6) @(posedge MCLK);
		regw(8'h00, 1'b1);
		check("unlocked", 32'({STATUS_WRITE_DISABLE_BIT, BP}), 0);
		check("notes left", expq.size(), 0);
		$display("test hardware protection done");
		stop_test();
	end
endmodule : sfg_guard_tb
